// *** sesr_pkg.sv ***
// Package for the video receiver error status register group.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
package sesr_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [3:0] IDX_ERR_PRI = 4'h2;
  localparam logic [3:0] IDX_ERR_SEC = 4'h3;
  localparam logic [3:0] IDX_RX_FLAGS = 4'h4;
  localparam logic [3:0] IDX_TX_FLAGS = 4'h5;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h8;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h9;

  // Bus shape
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // Primary error register field positions
  localparam int ERR_VSTD_BIT = 10;
  localparam int ERR_FF_CRC_BIT = 9;
  localparam int ERR_AP_CRC_BIT = 8;
  localparam int STREAM_ERR_W = 7;

  // Stream error field positions, shared by both streams
  localparam int SE_CHROMA_CS = 6;
  localparam int SE_LUMA_CS = 5;
  localparam int SE_CHROMA_CRC = 4;
  localparam int SE_LUMA_CRC = 3;
  localparam int SE_LINE_NUM = 2;
  localparam int SE_START_REF = 1;
  localparam int SE_END_REF = 0;

  // Integrity flag layout: three segments of five flags
  localparam int SEG_W = 5;
  localparam int FLAGS_W = 15;
  localparam int INT_FOUND_BIT = 15;

  // Outgoing flags reset: unknown-status set in all three segments
  localparam logic [FLAGS_W-1:0] TX_FLAGS_RST = 15'h4210;

  // Interrupt sources in the interrupt status register
  localparam int IRQ_W = 2;
  localparam int IRQ_PRI_BIT = 0;
  localparam int IRQ_SEC_BIT = 1;

  // Input rate of the current stream
  typedef enum logic [1:0] {
    SESR_RATE_SD = 2'h0,
    SESR_RATE_HD = 2'h1,
    SESR_RATE_3GA = 2'h3,
    SESR_RATE_3GB = 2'h2
  } sesr_rate_e;

  // One stream's error events, one-cycle pulses from the detectors
  typedef struct packed {
    logic chroma_checksum_error;
    logic luma_checksum_error;
    logic chroma_line_crc_error;
    logic luma_line_crc_error;
    logic line_number_error;
    logic start_ref_error;
    logic end_ref_error;
  } sesr_stream_err_s;

  // One integrity segment, high bit first
  typedef struct packed {
    logic unknown_status;
    logic internal_already;
    logic internal_here;
    logic error_already;
    logic error_here;
  } sesr_segment_s;

  // Three segments in register order
  typedef struct packed {
    sesr_segment_s anc;
    sesr_segment_s full_field;
    sesr_segment_s active_pic;
  } sesr_flags_s;

endpackage

// *** sesr_regs.sv ***
// Error status and integrity flag register group of a serial video receiver.
// Assumes detector pulses and flag levels arrive on core_clk from the video path.
// Operation
// - video standard error latched in bit 10, SD and HD only
// - full-frame and active-picture CRC errors, bits 9,8
// - stream one checksum errors bits 6,5, all rates
// - stream one line CRC errors, no SD
// - stream one line number error, no SD
// - stream one start/end reference errors, all rates
// - stream two errors, level B only
// - received ancillary segment flags in bits 14:10
// - received full-field segment flags in bits 9:5
// - received active-picture flags bits 4:0, reset zero
// - outgoing unknown-status flags reset to one
// - other outgoing flags read-only, reset zero

`timescale 1ns/1ps
`default_nettype none

module sesr_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [sesr_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [sesr_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [sesr_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // Video path status
  input wire sesr_pkg::sesr_rate_e input_rate,
  input wire logic video_standard_error_s1,
  input wire logic full_frame_crc_error,
  input wire logic active_picture_crc_error,
  input wire sesr_pkg::sesr_stream_err_s stream1_err,
  input wire sesr_pkg::sesr_stream_err_s stream2_err,
  input wire logic integrity_packet_found,
  input wire sesr_pkg::sesr_flags_s rx_flags,
  input wire sesr_pkg::sesr_flags_s tx_flags,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Word index from the byte address
  logic [3:0] word_idx;
  // Accept phase: one wait cycle, then answer
  logic ack;
  // Write strobe on the accept edge
  logic wr_go;
  // Low lanes hold all 16-bit registers
  logic low_lanes;
  // Index selects
  logic sel_pri;
  logic sel_sec;
  logic sel_stat;
  logic sel_mask;

  assign word_idx = address[5:2];
  assign waitrequest = (read | write) & ~ack;
  assign wr_go = write & ack;
  assign low_lanes = |byteenable[1:0];
  assign sel_pri = word_idx == sesr_pkg::IDX_ERR_PRI;
  assign sel_sec = word_idx == sesr_pkg::IDX_ERR_SEC;
  assign sel_stat = word_idx == sesr_pkg::IDX_IRQ_STAT;
  assign sel_mask = word_idx == sesr_pkg::IDX_IRQ_MASK;

  // Ack toggles so every access holds waitrequest high for one cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else begin
      ack <= (read | write) & ~ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event qualification by input rate

  // Rate class decodes
  logic is_sd;
  logic is_level_b;
  // Qualified events in register layout
  logic [sesr_pkg::REG_W-1:0] pri_set;
  logic [sesr_pkg::REG_W-1:0] sec_set;

  assign is_sd = input_rate == sesr_pkg::SESR_RATE_SD;
  assign is_level_b = input_rate == sesr_pkg::SESR_RATE_3GB;

  // Map pulses onto bit positions, gated where a rate cannot carry them
  always_comb begin
    pri_set = '0;
    sec_set = '0;
    // Video standard check exists only for HD and SD
    pri_set[sesr_pkg::ERR_VSTD_BIT] = video_standard_error_s1 & (is_sd |
      (input_rate == sesr_pkg::SESR_RATE_HD));
    pri_set[sesr_pkg::ERR_FF_CRC_BIT] = full_frame_crc_error;
    pri_set[sesr_pkg::ERR_AP_CRC_BIT] = active_picture_crc_error;
    pri_set[sesr_pkg::SE_CHROMA_CS] = stream1_err.chroma_checksum_error;
    pri_set[sesr_pkg::SE_LUMA_CS] = stream1_err.luma_checksum_error;
    // SD carries no line CRC or line number words
    pri_set[sesr_pkg::SE_CHROMA_CRC] = stream1_err.chroma_line_crc_error & ~is_sd;
    pri_set[sesr_pkg::SE_LUMA_CRC] = stream1_err.luma_line_crc_error & ~is_sd;
    pri_set[sesr_pkg::SE_LINE_NUM] = stream1_err.line_number_error & ~is_sd;
    pri_set[sesr_pkg::SE_START_REF] = stream1_err.start_ref_error;
    pri_set[sesr_pkg::SE_END_REF] = stream1_err.end_ref_error;
    // Second stream only exists in level B; upper bits stay zero
    if (is_level_b) begin
      sec_set[sesr_pkg::STREAM_ERR_W-1:0] = stream2_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky error registers

  // Latched error bits
  logic [sesr_pkg::REG_W-1:0] err_pri;
  logic [sesr_pkg::REG_W-1:0] err_sec;
  // Clear masks from the accepted write; a write to the register with a low byte lane enabled clears all its latched bits
  logic [sesr_pkg::REG_W-1:0] pri_clr;
  logic [sesr_pkg::REG_W-1:0] sec_clr;

  assign pri_clr = {sesr_pkg::REG_W{wr_go & sel_pri & low_lanes}};
  assign sec_clr = {sesr_pkg::REG_W{wr_go & sel_sec & low_lanes}};

  // Set beats clear so an event in the clear cycle survives
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      err_pri <= '0;
    end else begin
      err_pri <= (err_pri & ~pri_clr) | pri_set;
    end
  end

  // Second stream register, same policy
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      err_sec <= '0;
    end else begin
      err_sec <= (err_sec & ~sec_clr) | sec_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Integrity flag snapshots

  // Received flags with packet-found on top
  logic [sesr_pkg::REG_W-1:0] rx_reg;
  // Outgoing flags, top bit reserved zero
  logic [sesr_pkg::FLAGS_W-1:0] tx_reg;

  // Received flags follow the decoder each cycle; reset to zero
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rx_reg <= '0;
    end else begin
      rx_reg[sesr_pkg::INT_FOUND_BIT] <= integrity_packet_found;
      rx_reg[14:10] <= rx_flags.anc;
      rx_reg[9:5] <= rx_flags.full_field;
      rx_reg[4:0] <= rx_flags.active_pic;
    end
  end

  // Outgoing flags start as unknown status until the generator reports
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_reg <= sesr_pkg::TX_FLAGS_RST;
    end else begin
      tx_reg <= tx_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  // Sticky summary of new error events per register
  logic [sesr_pkg::IRQ_W-1:0] irq_stat;
  // Enables, reset masked
  logic [sesr_pkg::IRQ_W-1:0] irq_mask;
  // Events this cycle
  logic [sesr_pkg::IRQ_W-1:0] irq_ev;
  // Write-one-to-clear bits
  logic [sesr_pkg::IRQ_W-1:0] irq_w1c;

  assign irq_ev[sesr_pkg::IRQ_PRI_BIT] = |pri_set;
  assign irq_ev[sesr_pkg::IRQ_SEC_BIT] = |sec_set;
  assign irq_w1c = (wr_go & sel_stat & byteenable[0]) ?
    writedata[sesr_pkg::IRQ_W-1:0] : '0;

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_w1c) | irq_ev;
    end
  end

  // Mask register is plain read/write
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_mask <= '0;
    end else if (wr_go & sel_mask & byteenable[0]) begin
      irq_mask <= writedata[sesr_pkg::IRQ_W-1:0];
    end
  end

  // Level output from a flop to keep it glitch free
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data and response

  // Read mux value
  logic [sesr_pkg::DATA_W-1:0] rd_mux;
  // Address hits a mapped register
  logic hit;

  // Select the addressed register; unmapped reads as zero
  always_comb begin
    rd_mux = '0;
    hit = 1'b1;
    case (word_idx)
      sesr_pkg::IDX_ERR_PRI: rd_mux[sesr_pkg::REG_W-1:0] = err_pri;
      sesr_pkg::IDX_ERR_SEC: rd_mux[sesr_pkg::REG_W-1:0] = err_sec;
      sesr_pkg::IDX_RX_FLAGS: rd_mux[sesr_pkg::REG_W-1:0] = rx_reg;
      sesr_pkg::IDX_TX_FLAGS: rd_mux[sesr_pkg::FLAGS_W-1:0] = tx_reg;
      sesr_pkg::IDX_IRQ_STAT: rd_mux[sesr_pkg::IRQ_W-1:0] = irq_stat;
      sesr_pkg::IDX_IRQ_MASK: rd_mux[sesr_pkg::IRQ_W-1:0] = irq_mask;
      default: hit = 1'b0;
    endcase
  end

  // Read data registered in the wait cycle, valid on the accept edge
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      readdata <= '0;
    end else if (read & ~ack) begin
      readdata <= rd_mux;
    end
  end

  // Unmapped addresses answer with a decode error
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      response <= 2'h0;
    end else if ((read | write) & ~ack) begin
      response <= hit ? 2'h0 : 2'h3;
    end
  end

endmodule

`default_nettype wire

// *** sesr_regs_checker.sv ***
// Concurrent checks on the error status register group ports.
// Assumes it is bound to sesr_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sesr_regs_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  // Flags and interrupt
  input wire sesr_pkg::sesr_flags_s rx_flags,
  input wire sesr_pkg::sesr_flags_s tx_flags,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // Accepted read and decoded word index
  logic acc_rd;
  logic [3:0] idx;
  logic mapped;
  assign acc_rd = read && !waitrequest;
  assign idx = address[5:2];
  assign mapped = idx inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
  ////////////////////////////////////////////////////////////////////////////////
  a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait state longer than one cycle");
  a_idle_no_wait: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest without request");
  a_unmapped_decode: assert property ((read || write) && !waitrequest && !mapped
    |-> response == 2'h3) else $error("unmapped access not refused");
  a_mapped_okay: assert property (acc_rd && mapped |-> response == 2'h0)
    else $error("mapped read not okay");
  a_primary_rsvd_zero: assert property (
    acc_rd && idx == 4'h2 |-> readdata[31:11] == '0) else $error("primary reserved set");
  a_second_rsvd_zero: assert property (
    acc_rd && idx == 4'h3 |-> readdata[31:7] == '0) else $error("secondary reserved set");
  a_rx_mirror: assert property (
    acc_rd && idx == 4'h4 && $stable(rx_flags) && rx_flags == $past(rx_flags, 2)
    |-> readdata[14:0] == rx_flags && readdata[31:16] == '0) else $error("rx flags wrong");
  a_tx_mirror: assert property (
    acc_rd && idx == 4'h5 && $stable(tx_flags) && tx_flags == $past(tx_flags, 2)
    |-> readdata[14:0] == tx_flags && readdata[31:15] == '0) else $error("tx flags wrong");
  a_irq_reset_low: assert property ($rose(rstn) |-> !irq)
    else $error("irq high after reset");
  // Main scenarios reached
  c_unmapped: cover property (acc_rd && !mapped);
  c_irq: cover property ($rose(irq));
  c_clear: cover property (write && !waitrequest && idx == 4'h2);
endmodule
`default_nettype wire

// *** sesr_regs_tb_top.sv ***
// Self-checking bench for the error status register group.
// Assumes sesr_pkg and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sesr_regs_tb_top;
  // Design signals
  logic core_clk, rstn, read, write, waitrequest, irq, integrity_packet_found;
  logic video_standard_error_s1, full_frame_crc_error, active_picture_crc_error;
  logic [5:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic [1:0] response;
  sesr_pkg::sesr_rate_e input_rate;
  sesr_pkg::sesr_stream_err_s stream1_err, stream2_err;
  sesr_pkg::sesr_flags_s rx_flags, tx_flags;
  int errors, comparisons, cycles;
  // One row: rate, events {vstd,ff,ap,s1}, s2 events, expected registers
  typedef struct packed {
    sesr_pkg::sesr_rate_e rate;
    logic [9:0] e1;
    logic [6:0] e2;
    logic [15:0] p;
    logic [15:0] s;
  } sesr_row_s;
  sesr_row_s rows [7] = '{
    '{sesr_pkg::SESR_RATE_SD, 10'h080, 7'h00, 16'h0100, 16'h0000},
    '{sesr_pkg::SESR_RATE_SD, 10'h3FF, 7'h7F, 16'h0763, 16'h0000},
    '{sesr_pkg::SESR_RATE_3GA, 10'h3FF, 7'h7F, 16'h037F, 16'h0000},
    '{sesr_pkg::SESR_RATE_3GB, 10'h3FF, 7'h7F, 16'h037F, 16'h007F},
    '{sesr_pkg::SESR_RATE_3GB, 10'h200, 7'h00, 16'h0000, 16'h0000},
    '{sesr_pkg::SESR_RATE_3GB, 10'h100, 7'h00, 16'h0200, 16'h0000},
    '{sesr_pkg::SESR_RATE_HD, 10'h3FF, 7'h7F, 16'h077F, 16'h0000}};
  sesr_regs dut (.core_clk(core_clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .input_rate(input_rate),
    .video_standard_error_s1(video_standard_error_s1), .irq(irq),
    .full_frame_crc_error(full_frame_crc_error), .stream1_err(stream1_err),
    .active_picture_crc_error(active_picture_crc_error), .stream2_err(stream2_err),
    .integrity_packet_found(integrity_packet_found), .rx_flags(rx_flags),
    .tx_flags(tx_flags));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      conclude();
    end
  end
  // Verdict, reached from the hang guard and from the end of the sequence
  task automatic conclude();
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus cycle: hold until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // One-cycle detector pulses
  task automatic pulse(input logic [9:0] a, input logic [6:0] b);
    @(posedge core_clk);
    {video_standard_error_s1, full_frame_crc_error, active_picture_crc_error, stream1_err} <= a;
    stream2_err <= b;
    @(posedge core_clk);
    {video_standard_error_s1, full_frame_crc_error, active_picture_crc_error, stream1_err} <= '0;
    stream2_err <= '0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {core_clk, rstn, read, write, integrity_packet_found, errors, comparisons, cycles} = '0;
    {video_standard_error_s1, full_frame_crc_error, active_picture_crc_error} = '0;
    {address, writedata, stream1_err, stream2_err, rx_flags} = '0;
    byteenable = 4'hF;
    input_rate = sesr_pkg::SESR_RATE_SD;
    tx_flags = 15'h4210;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    // Reset values
    bus(0, 6'h08, 0); chk(rd, 0);
    bus(0, 6'h0C, 0); chk(rd, 0);
    bus(0, 6'h10, 0); chk(rd, 0);
    bus(0, 6'h14, 0); chk(rd, 32'h4210);
    // Table of rates and events
    foreach (rows[i]) begin
      input_rate <= rows[i].rate;
      bus(1, 6'h08, 0);
      bus(1, 6'h0C, 0);
      pulse(rows[i].e1, rows[i].e2);
      bus(0, 6'h08, 0); chk(rd, {16'h0, rows[i].p});
      bus(0, 6'h0C, 0); chk(rd, {16'h0, rows[i].s});
    end
    // Sticky until written, then cleared; event at the clear edge wins
    bus(0, 6'h08, 0); chk(rd, 32'h077F);
    bus(1, 6'h08, 0); bus(0, 6'h08, 0); chk(rd, 0);
    video_standard_error_s1 <= 1'b1;
    bus(1, 6'h08, 0);
    video_standard_error_s1 <= 1'b0;
    bus(0, 6'h08, 0); chk(rd, 32'h0400);
    // Read-only flag registers ignore writes
    rx_flags <= 15'h2AD5;
    integrity_packet_found <= 1'b1;
    tx_flags <= 15'h1234;
    bus(1, 6'h10, 32'hFFFF); bus(0, 6'h10, 0); chk(rd, 32'hAAD5);
    bus(1, 6'h14, 32'hFFFF); bus(0, 6'h14, 0); chk(rd, 32'h1234);
    // Unmapped read refused
    bus(0, 6'h3C, 0); chk(rd, 0);
    chk({30'h0, response}, 32'h3);
    // Interrupt raised, cleared, masked
    bus(1, 6'h24, 1); bus(1, 6'h20, 3);
    pulse(10'h001, 0); repeat (3) @(posedge core_clk); chk({31'h0, irq}, 1);
    bus(1, 6'h20, 3); repeat (2) @(posedge core_clk); chk({31'h0, irq}, 0);
    bus(1, 6'h24, 0);
    pulse(10'h001, 0); repeat (3) @(posedge core_clk); chk({31'h0, irq}, 0);
    bus(0, 6'h20, 0); chk({31'h0, rd[0]}, 1);
    // Second reset mid-run
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    bus(0, 6'h08, 0); chk(rd, 0);
    conclude();
  end
endmodule
bind sesr_regs sesr_regs_checker u_chk (.core_clk(core_clk), .rstn(rstn),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .response(response), .rx_flags(rx_flags),
  .tx_flags(tx_flags), .irq(irq));
`default_nettype wire
